/* logic/mad_consts.svh */
/*
 Constants of the address decoder: map boundaries, state counts,
 strap codes and reset values.
 Assumes a 16-bit CPU address and a byte-wide external bus.
*/
`ifndef MAD_CONSTS_SVH
`define MAD_CONSTS_SVH

// mode pin codes {high, low}
`define MAD_PINS_M1        2'h1
`define MAD_PINS_M2        2'h2
`define MAD_PINS_M3        2'h3

// memory size strap
`define MAD_SIZE_LARGE     2'h0
`define MAD_SIZE_MEDIUM    2'h1
`define MAD_SIZE_SMALL     2'h2

// top of on-chip ROM per size
`define MAD_ROM_TOP_LARGE  16'hefff
`define MAD_ROM_TOP_MEDIUM 16'h7fff
`define MAD_ROM_TOP_SMALL  16'h3fff

// base of on-chip RAM per size, RAM ends at one fixed top
`define MAD_RAM_BASE_LARGE  16'hf780
`define MAD_RAM_BASE_MEDIUM 16'hfb80
`define MAD_RAM_BASE_SMALL  16'hfd80
`define MAD_RAM_TOP         16'hff7f

// gaps and register blocks in the top page
`define MAD_GAP1_LO        16'hff80
`define MAD_GAP1_HI        16'hff8f
`define MAD_REG1_LO        16'hff90
`define MAD_REG1_HI        16'hff9f
`define MAD_GAP2_LO        16'hffa0
`define MAD_GAP2_HI        16'hffaf
`define MAD_REG2_LO        16'hffb0
`define MAD_IO_PAGE        8'hff

// access lengths in system clock cycles
`define MAD_ONCHIP_STATES  3'h2
`define MAD_BYTE_STATES    3'h3
`define MAD_FIRST_STATE    3'h1

// data and reset values
`define MAD_ALL_ONES       16'hffff
`define MAD_HIGH_BYTE_ZERO 8'h00
`define MAD_RAMEN_RST      1'h1
`define MAD_IOSEL_IDLE     1'h1

`endif

/* logic/mad_decoder.sv */
/*
 Address decoder and access sequencer between the CPU and on-chip
 ROM, on-chip RAM, the register field and the external bus.
 Assumes targets read their data from busAddr while their select is
 high and present read data in the last cycle of the access.
*/
`timescale 1ns/10ps
`include "mad_consts.svh"

module mad_decoder (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // straps and pins
    input  wire logic        modePinHigh,
    input  wire logic        modePinLow,
    input  wire logic [1:0]  memSizePins,
    input  wire logic        extWaitPin,
    // RAM enable bit write
    input  wire logic        ramEnWr,
    input  wire logic        ramEnData,
    // CPU request
    input  wire logic        cpuReq,
    input  wire logic [15:0] cpuAddr,
    input  wire logic        cpuWrite,
    // target read data
    input  wire logic [15:0] romRdata,
    input  wire logic [15:0] ramRdata,
    input  wire logic [7:0]  regRdata,
    input  wire logic [7:0]  extRdata,
    // CPU answer
    output logic             cpuBusy,
    output logic             cpuDone,
    output logic      [15:0] cpuRdata,
    // target selects
    output logic             selRom,
    output logic             selRam,
    output logic             selReg,
    output logic             selExt,
    output logic             accWord,
    output logic      [15:0] busAddr,
    output logic             busWrite,
    output logic             ioPageSelN,
    // status
    output logic             onchipRamEnableBit,
    output logic             modeInvalid
);

    mad_pkg::mad_core_t   q;
    mad_pkg::mad_core_t   d;
    mad_pkg::mad_mode_t   mode;
    mad_pkg::mad_target_t decTgt;
    logic [3:0]           straps;
    logic                 waitReq;
    logic [2:0]           need;
    logic                 last;
    logic                 modeInvalid_q;
    logic                 nullRead;
    logic                 expandedMode;
    logic                 taking;

    function automatic logic [2:0] needStates(input mad_pkg::mad_target_t t);
        if (t == mad_pkg::TGT_ROM || t == mad_pkg::TGT_RAM) begin
            return `MAD_ONCHIP_STATES;
        end
        return `MAD_BYTE_STATES;
    endfunction

    mad_pin_sync u_sync (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .modePinHigh (modePinHigh),
        .modePinLow  (modePinLow),
        .memSizePins (memSizePins),
        .extWaitPin  (extWaitPin),
        .strapHeld   (straps),
        .waitReq     (waitReq)
    );

    // mode held from the pins seen at reset release
    always_comb begin
        case (straps[3:2])
            `MAD_PINS_M1: mode = mad_pkg::MODE_EXP_NOROM;
            `MAD_PINS_M2: mode = mad_pkg::MODE_EXP_ROM;
            `MAD_PINS_M3: mode = mad_pkg::MODE_SINGLE;
            default:      mode = mad_pkg::MODE_INVALID;
        endcase
    end

    mad_region_decode u_dec (
        .addr    (cpuAddr),
        .mode    (mode),
        .memSize (straps[1:0]),
        .ramEn   (q.ramEn),
        .tgt     (decTgt)
    );

    always_comb begin
        need = needStates(q.tgt);
        // wait only stretches external cycles
        last = (q.cnt == need) && !(q.tgt == mad_pkg::TGT_EXT && waitReq);
    end

    always_comb begin
        d = q;
        d.done = 1'b0;
        case (q.seq)
            mad_pkg::ST_IDLE: begin
                // requests while busy are not taken
                if (cpuReq) begin
                    d.seq = mad_pkg::ST_ACCESS;
                    d.tgt = decTgt;
                    d.cnt = `MAD_FIRST_STATE;
                    d.addr = cpuAddr;
                    d.wr = cpuWrite;
                    d.selRom = (decTgt == mad_pkg::TGT_ROM);
                    d.selRam = (decTgt == mad_pkg::TGT_RAM);
                    d.selReg = (decTgt == mad_pkg::TGT_REG);
                    d.selExt = (decTgt == mad_pkg::TGT_EXT);
                    d.accWord = d.selRom || d.selRam;
                    d.ioN = ~(cpuAddr[15:8] == `MAD_IO_PAGE);
                end
            end
            mad_pkg::ST_ACCESS: begin
                if (last) begin
                    d.seq = mad_pkg::ST_IDLE;
                    d.selRom = 1'b0;
                    d.selRam = 1'b0;
                    d.selReg = 1'b0;
                    d.selExt = 1'b0;
                    d.accWord = 1'b0;
                    d.ioN = `MAD_IOSEL_IDLE;
                    d.done = 1'b1;
                    if (!q.wr) begin
                        case (q.tgt)
                            mad_pkg::TGT_ROM: d.rdata = romRdata;
                            mad_pkg::TGT_RAM: d.rdata = ramRdata;
                            mad_pkg::TGT_REG: d.rdata = {`MAD_HIGH_BYTE_ZERO, regRdata};
                            mad_pkg::TGT_EXT: d.rdata = {`MAD_HIGH_BYTE_ZERO, extRdata};
                            default:          d.rdata = `MAD_ALL_ONES;
                        endcase
                    end
                end else if (q.cnt != need) begin
                    d.cnt = q.cnt + `MAD_FIRST_STATE;
                end
            end
            default: begin
                d.seq = mad_pkg::ST_IDLE;
            end
        endcase
        // a write steers decode from the next request on
        if (ramEnWr) begin
            d.ramEn = ramEnData;
        end
        if (!rst_n) begin
            d = '0;
            d.ramEn = `MAD_RAMEN_RST;
            d.ioN = `MAD_IOSEL_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        q <= d;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            modeInvalid_q <= 1'b0;
        end else begin
            modeInvalid_q <= (mode == mad_pkg::MODE_INVALID);
        end
    end

    assign cpuBusy            = (q.seq == mad_pkg::ST_ACCESS);
    assign cpuDone            = q.done;
    assign cpuRdata           = q.rdata;
    assign selRom             = q.selRom;
    assign selRam             = q.selRam;
    assign selReg             = q.selReg;
    assign selExt             = q.selExt;
    assign accWord            = q.accWord;
    assign busAddr            = q.addr;
    assign busWrite           = q.wr;
    assign ioPageSelN         = q.ioN;
    assign onchipRamEnableBit = q.ramEn;
    assign modeInvalid        = modeInvalid_q;

    assign nullRead = (q.seq == mad_pkg::ST_ACCESS) && (q.tgt == mad_pkg::TGT_VOID) && !q.wr;
    assign expandedMode = (mode == mad_pkg::MODE_EXP_NOROM) || (mode == mad_pkg::MODE_EXP_ROM);
    assign taking       = cpuReq && (q.seq == mad_pkg::ST_IDLE);

    // a void access runs with no select, so TGT_VOID accesses must be left out of the match
    one_select_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $onehot0({q.selRom, q.selRam, q.selReg, q.selExt}) &&
        ((q.selRom || q.selRam || q.selReg || q.selExt) ==
         (q.seq == mad_pkg::ST_ACCESS && q.tgt != mad_pkg::TGT_VOID)))
        else $error("target selects not one per access");

    no_ext_single_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (mode == mad_pkg::MODE_SINGLE || mode == mad_pkg::MODE_INVALID) |-> !q.selExt)
        else $error("external cycle outside expanded mode");

    onchip_two_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(q.selRom || q.selRam) |->
            (q.accWord && (q.selRom || q.selRam))[*2] ##1 !(q.selRom || q.selRam) && q.done)
        else $error("on-chip memory access not two word cycles");

    regfield_three_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(q.selReg) |-> (q.selReg && !q.accWord)[*3] ##1 !q.selReg && q.done)
        else $error("register field access not three byte cycles");

    ext_least_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(q.selExt) |-> (q.selExt && !q.accWord)[*3])
        else $error("external cycle shorter than three cycles");

    ext_wait_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        q.selExt && q.cnt == `MAD_BYTE_STATES && waitReq |=> q.selExt && !q.done)
        else $error("external cycle ended under wait request");

    io_page_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cpuBusy |-> ioPageSelN == (busAddr[15:8] != `MAD_IO_PAGE))
        else $error("io page select wrong for access address");

    io_idle_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !cpuBusy |-> ioPageSelN)
        else $error("io page select low with no access");

    void_ones_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        nullRead && last |=> cpuDone && cpuRdata == `MAD_ALL_ONES)
        else $error("off-chip read in single-chip mode not all ones");

    ram_gate_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(q.selRam) |-> $past(q.ramEn) || !expandedMode)
        else $error("RAM selected while disabled in expanded mode");

    mode_flag_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $past(rst_n) |-> modeInvalid == $past(mode == mad_pkg::MODE_INVALID))
        else $error("invalid mode flag does not follow the straps");

    ram_reset_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !$past(rst_n) |-> onchipRamEnableBit)
        else $error("RAM enable not set after reset");

    done_pulse_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cpuDone |-> !cpuBusy ##1 !cpuDone)
        else $error("done not a single idle cycle");

    addr_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cpuBusy && $past(cpuBusy) |-> $stable(busAddr) && $stable(busWrite))
        else $error("address or direction moved during an access");

    gap_ext_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        taking && expandedMode &&
        ((cpuAddr >= `MAD_GAP1_LO && cpuAddr <= `MAD_GAP1_HI) ||
         (cpuAddr >= `MAD_GAP2_LO && cpuAddr <= `MAD_GAP2_HI)) |=> selExt)
        else $error("gap address not sent to the external bus");

    reg_field_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        taking && (cpuAddr >= `MAD_REG2_LO ||
                   (cpuAddr >= `MAD_REG1_LO && cpuAddr <= `MAD_REG1_HI)) |=> selReg)
        else $error("register address not sent to the register field");

    // the large variant has the lowest RAM base, so this holds for every size
    low_ext_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        taking && mode == mad_pkg::MODE_EXP_NOROM && cpuAddr < `MAD_RAM_BASE_LARGE |=> selExt)
        else $error("address below RAM not external without ROM");

    rom_low_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        taking && mode == mad_pkg::MODE_SINGLE && cpuAddr <= `MAD_ROM_TOP_SMALL |=> selRom)
        else $error("low address not sent to ROM in single-chip mode");

    ram_range_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        taking && (q.ramEn || !expandedMode) &&
        cpuAddr >= `MAD_RAM_BASE_SMALL && cpuAddr <= `MAD_RAM_TOP |=> selRam)
        else $error("enabled RAM address not sent to on-chip RAM");

endmodule

/* logic/mad_pin_sync.sv */
/*
 Pin synchroniser: three flops per pin, a change counts once the
 second and third agree. Straps are held from the last agreed value
 seen while reset is low; the wait request is tracked always.
 Assumes rst_n is held low long enough for the chain to settle.
*/
`timescale 1ns/10ps
`include "mad_consts.svh"

module mad_pin_sync (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // pins
    input  wire logic       modePinHigh,
    input  wire logic       modePinLow,
    input  wire logic [1:0] memSizePins,
    input  wire logic       extWaitPin,
    // filtered levels
    output logic      [3:0] strapHeld,
    output logic            waitReq
);

    mad_pkg::mad_sync_t q;
    mad_pkg::mad_sync_t d;
    logic [4:0]         agree;

    always_comb begin
        d = q;
        agree = ~(q.s2 ^ q.s3);
        d.s1 = {modePinHigh, modePinLow, memSizePins, extWaitPin};
        d.s2 = q.s1;
        d.s3 = q.s2;
        // straps follow the pins only while reset is asserted
        if (!rst_n) begin
            d.straps = (agree[4:1] & q.s3[4:1]) | (~agree[4:1] & q.straps);
        end
        if (agree[0]) begin
            d.waitReq = q.s3[0];
        end
    end

    // no reset: the chain must keep sampling through reset
    always_ff @(posedge sys_clk) begin
        q <= d;
    end

    assign strapHeld = q.straps;
    assign waitReq   = q.waitReq;

endmodule

/* logic/mad_pkg.sv */
/*
 Types of the address decoder: modes, targets, sequencer states and
 the packed state records of its modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package mad_pkg;

    typedef enum logic [1:0] {
        MODE_INVALID,
        MODE_EXP_NOROM,
        MODE_EXP_ROM,
        MODE_SINGLE
    } mad_mode_t;

    typedef enum logic [2:0] {
        TGT_VOID,
        TGT_ROM,
        TGT_RAM,
        TGT_REG,
        TGT_EXT
    } mad_target_t;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_ACCESS
    } mad_seq_t;

    // {modeHigh, modeLow, size[1:0], wait}
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [3:0] straps;
        logic       waitReq;
    } mad_sync_t;

    typedef struct packed {
        mad_seq_t    seq;
        mad_target_t tgt;
        logic [2:0]  cnt;
        logic [15:0] addr;
        logic        wr;
        logic        ramEn;
        logic        selRom;
        logic        selRam;
        logic        selReg;
        logic        selExt;
        logic        accWord;
        logic        ioN;
        logic        done;
        logic [15:0] rdata;
    } mad_core_t;

endpackage

/* logic/mad_region_decode.sv */
/*
 Address map decode: picks the target of one CPU address from the
 operating mode, memory size variant and RAM enable.
 Assumes the caller starts no external cycle outside expanded modes;
 off-chip space in other modes comes back as the void target.
*/
`timescale 1ns/10ps
`include "mad_consts.svh"

module mad_region_decode (
    // access
    input  wire logic [15:0]  addr,
    // configuration
    input  mad_pkg::mad_mode_t mode,
    input  wire logic [1:0]   memSize,
    input  wire logic         ramEn,
    // result
    output mad_pkg::mad_target_t tgt
);

    logic [15:0] romTop;
    logic [15:0] ramBase;
    logic        expanded;
    logic        offChip;

    always_comb begin
        case (memSize)
            `MAD_SIZE_MEDIUM: begin
                romTop  = `MAD_ROM_TOP_MEDIUM;
                ramBase = `MAD_RAM_BASE_MEDIUM;
            end
            `MAD_SIZE_SMALL: begin
                romTop  = `MAD_ROM_TOP_SMALL;
                ramBase = `MAD_RAM_BASE_SMALL;
            end
            default: begin
                romTop  = `MAD_ROM_TOP_LARGE;
                ramBase = `MAD_RAM_BASE_LARGE;
            end
        endcase
        expanded = (mode == mad_pkg::MODE_EXP_NOROM) || (mode == mad_pkg::MODE_EXP_ROM);
        offChip = 1'b0;
        tgt = mad_pkg::TGT_VOID;
        if (addr >= `MAD_REG2_LO ||
            (addr >= `MAD_REG1_LO && addr <= `MAD_REG1_HI)) begin
            tgt = mad_pkg::TGT_REG;
        end else if ((addr >= `MAD_GAP1_LO && addr <= `MAD_GAP1_HI) ||
                     (addr >= `MAD_GAP2_LO && addr <= `MAD_GAP2_HI)) begin
            offChip = 1'b1;
        end else if (addr >= ramBase && addr <= `MAD_RAM_TOP) begin
            if (ramEn || !expanded) begin
                tgt = mad_pkg::TGT_RAM;
            end else begin
                offChip = 1'b1;
            end
        end else if (mode != mad_pkg::MODE_EXP_NOROM && addr <= romTop) begin
            tgt = mad_pkg::TGT_ROM;
        end else begin
            offChip = 1'b1;
        end
        if (offChip && expanded) begin
            tgt = mad_pkg::TGT_EXT;
        end
    end

endmodule

/* tb/mad_decoder_tb_top.sv */
/*
 Testbench of the address decoder: a table of reads across modes and
 size variants, then reset, RAM enable, wait and invalid-strap cases.
 Assumes on-chip targets answer with a pattern of busAddr.
*/
`timescale 1ns/10ps

module mad_decoder_tb_top;
    typedef struct packed {
        logic [1:0]  pins;
        logic [1:0]  size;
        logic [15:0] addr;
        logic [3:0]  sel;
        logic [5:0]  n;
    } mad_row_t;

    logic        sys_clk, rst_n, modePinHigh, modePinLow, extWaitPin;
    logic        ramEnWr, ramEnData, cpuReq, cpuWrite, cpuBusy, cpuDone;
    logic        selRom, selRam, selReg, selExt, accWord, busWrite;
    logic        ioPageSelN, onchipRamEnableBit, modeInvalid, wordSeen;
    logic [1:0]  memSizePins;
    logic [3:0]  waitLen;
    logic [7:0]  regRdata, extRdata;
    logic [15:0] cpuAddr, romRdata, ramRdata, cpuRdata, busAddr;
    int          err_count, cmp_count;

    // selects {rom, ram, reg, ext}; 0 means nothing selected
    localparam mad_row_t ROWS [24] = '{
        '{2'h3, 2'h0, 16'h0000, 4'h8, 6'h2}, '{2'h3, 2'h0, 16'hefff, 4'h8, 6'h2},
        '{2'h3, 2'h0, 16'hf000, 4'h0, 6'h3}, '{2'h3, 2'h0, 16'hf780, 4'h4, 6'h2},
        '{2'h3, 2'h0, 16'hff7f, 4'h4, 6'h2}, '{2'h3, 2'h0, 16'hff80, 4'h0, 6'h3},
        '{2'h3, 2'h0, 16'hff90, 4'h2, 6'h3}, '{2'h3, 2'h0, 16'hffa5, 4'h0, 6'h3},
        '{2'h3, 2'h0, 16'hffff, 4'h2, 6'h3}, '{2'h2, 2'h1, 16'h7fff, 4'h8, 6'h2},
        '{2'h2, 2'h1, 16'h8000, 4'h1, 6'h3}, '{2'h2, 2'h1, 16'hfb80, 4'h4, 6'h2},
        '{2'h2, 2'h1, 16'hfb7f, 4'h1, 6'h3}, '{2'h2, 2'h1, 16'hff85, 4'h1, 6'h3},
        '{2'h2, 2'h1, 16'hff9f, 4'h2, 6'h3}, '{2'h2, 2'h1, 16'hffaf, 4'h1, 6'h3},
        '{2'h2, 2'h1, 16'hffb0, 4'h2, 6'h3}, '{2'h1, 2'h2, 16'h0000, 4'h1, 6'h3},
        '{2'h1, 2'h2, 16'h3fff, 4'h1, 6'h3}, '{2'h1, 2'h2, 16'hfd80, 4'h4, 6'h2},
        '{2'h1, 2'h2, 16'hfd7f, 4'h1, 6'h3}, '{2'h1, 2'h2, 16'hffa0, 4'h1, 6'h3},
        '{2'h1, 2'h2, 16'hff8f, 4'h1, 6'h3}, '{2'h1, 2'h2, 16'hffc4, 4'h2, 6'h3}
    };

    assign romRdata = busAddr ^ 16'h5a5a;
    assign ramRdata = ~busAddr;
    assign regRdata = busAddr[7:0] ^ 8'h3c;

    mad_decoder mad_decoder_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .modePinHigh(modePinHigh), .modePinLow(modePinLow), .memSizePins(memSizePins),
        .extWaitPin(extWaitPin), .ramEnWr(ramEnWr), .ramEnData(ramEnData),
        .cpuReq(cpuReq), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite), .romRdata(romRdata),
        .ramRdata(ramRdata), .regRdata(regRdata), .extRdata(extRdata),
        .cpuBusy(cpuBusy), .cpuDone(cpuDone), .cpuRdata(cpuRdata), .selRom(selRom),
        .selRam(selRam), .selReg(selReg), .selExt(selExt), .accWord(accWord),
        .busAddr(busAddr), .busWrite(busWrite), .ioPageSelN(ioPageSelN),
        .onchipRamEnableBit(onchipRamEnableBit), .modeInvalid(modeInvalid));

    mad_ext_dev mad_ext_dev_inst (.sys_clk(sys_clk), .selExt(selExt),
        .busAddr(busAddr), .waitLen(waitLen), .extRdata(extRdata),
        .extWaitPin(extWaitPin));

    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [15:0] exp_data(input logic [3:0] sel, input logic [15:0] a);
        case (sel)
            4'h8:    return a ^ 16'h5a5a;
            4'h4:    return ~a;
            4'h2:    return {8'h00, a[7:0] ^ 8'h3c};
            4'h1:    return {8'h00, a[7:0] ^ 8'h96};
            default: return 16'hffff;
        endcase
    endfunction

    // straps are taken while reset is low; settle one edge past release
    task automatic setup(input logic [1:0] pins, input logic [1:0] size);
        rst_n <= 1'h0;
        {modePinHigh, modePinLow} <= pins;
        memSizePins <= size;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'h1;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic acc(input logic [15:0] a, input logic w, output logic [5:0] n,
                       output logic [3:0] sel, output logic io, output logic [15:0] rd);
        int i;
        sel = 4'h0;
        io  = 1'h0;
        wordSeen = 1'h0;
        @(posedge sys_clk);
        cpuReq   <= 1'h1;
        cpuAddr  <= a;
        cpuWrite <= w;
        @(posedge sys_clk);
        cpuReq <= 1'h0;
        for (i = 1; i < 40; i++) begin
            @(posedge sys_clk);
            #1;
            if (cpuDone === 1'h1) break;
            sel |= {selRom, selRam, selReg, selExt};
            io  |= ~ioPageSelN;
            wordSeen |= accWord;
        end
        if (i == 40) begin
            err_count++;
            $display("wrong value done expected 1 seen 0");
            finish_test();
        end
        n  = i[5:0];
        rd = cpuRdata;
    endtask

    task automatic run(input logic [15:0] a, input logic [3:0] es, input logic [5:0] en);
        logic [5:0]  n;
        logic [3:0]  s;
        logic        io;
        logic [15:0] rd;
        acc(a, 1'h0, n, s, io, rd);
        check("selects", {12'h0, es}, {12'h0, s});
        check("cycles", {10'h0, en}, {10'h0, n});
        check("read data", exp_data(es, a), rd);
        check("io page", {15'h0, a[15:8] == 8'hff}, {15'h0, io});
        check("word width", {15'h0, es[3] | es[2]}, {15'h0, wordSeen});
        check("bus address", a, busAddr);
        check("busy after done", 16'h0, {15'h0, cpuBusy});
    endtask

    initial begin
        logic [3:0]  cfg;
        logic [5:0]  n;
        logic [3:0]  s;
        logic        io;
        logic [15:0] rd;
        rst_n = 1'h0;
        {modePinHigh, modePinLow, memSizePins} = 4'hf;
        {ramEnWr, ramEnData, cpuReq, cpuWrite} = 4'h4;
        cpuAddr = 16'h0000;
        waitLen = 4'h0;
        err_count = 0;
        cmp_count = 0;
        cfg = 4'h0;
        for (int k = 0; k < 24; k++) begin
            if ({ROWS[k].pins, ROWS[k].size} !== cfg) begin
                cfg = {ROWS[k].pins, ROWS[k].size};
                setup(ROWS[k].pins, ROWS[k].size);
            end
            run(ROWS[k].addr, ROWS[k].sel, ROWS[k].n);
        end
        setup(2'h2, 2'h0);
        check("ram enable", 16'h1, {15'h0, onchipRamEnableBit});
        check("idle io page", 16'h1, {15'h0, ioPageSelN});
        check("mode flag", 16'h0, {15'h0, modeInvalid});
        // clearing the enable hands the RAM range to the bus
        @(posedge sys_clk);
        ramEnWr   <= 1'h1;
        ramEnData <= 1'h0;
        @(posedge sys_clk);
        ramEnWr <= 1'h0;
        run(16'hf780, 4'h1, 6'h3);
        run(16'hff7f, 4'h1, 6'h3);
        // slow device: pin sync adds latency, so only a window is fixed
        waitLen <= 4'h5;
        repeat (4) @(posedge sys_clk);
        acc(16'hff8a, 1'h0, n, s, io, rd);
        check("wait stretch", 16'h1, {15'h0, n > 6'h3 && n < 6'hd});
        check("wait data", {8'h00, 8'h8a ^ 8'h96}, rd);
        waitLen <= 4'h0;
        setup(2'h2, 2'h0);
        run(16'hf780, 4'h4, 6'h2);
        setup(2'h0, 2'h0);
        check("mode flag", 16'h1, {15'h0, modeInvalid});
        run(16'hff85, 4'h0, 6'h3);
        setup(2'h3, 2'h0);
        acc(16'hffa2, 1'h1, n, s, io, rd);
        check("write selects", 16'h0, {12'h0, s});
        check("write direction", 16'h1, {15'h0, busWrite});
        check("write data", 16'h0, rd);
        setup(2'h3, 2'h3);
        run(16'hf780, 4'h4, 6'h2);
        run(16'hefff, 4'h8, 6'h2);
        finish_test();
    end
endmodule

/* tb/mad_ext_dev.sv */
/*
 External device on the expanded bus: returns a byte pattern of the
 address while selected and can stretch a cycle by a number of waits.
 Assumes selects and busAddr come from the decoder's registers.
*/
`timescale 1ns/10ps

module mad_ext_dev (
    // clock
    input  wire logic        sys_clk,
    // bus side
    input  wire logic        selExt,
    input  wire logic [15:0] busAddr,
    // test control
    input  wire logic [3:0]  waitLen,
    // answers
    output logic      [7:0]  extRdata,
    output logic             extWaitPin
);
    logic [3:0] cnt_q;
    logic [7:0] idle_q;

    always_ff @(posedge sys_clk) begin
        if (!selExt) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != 4'hf) begin
            cnt_q <= cnt_q + 4'h1;
        end
        // released data lines invert each cycle, so stale data comes back only every second idle cycle
        idle_q <= ~extRdata;
    end

    // wait stands ahead of the cycle: the pin synchroniser is too slow
    // for a request that only starts with the select
    assign extWaitPin = (cnt_q < waitLen);
    assign extRdata   = selExt ? (busAddr[7:0] ^ 8'h96) : idle_q;
endmodule
